//--- ofr_top.sv
`timescale 1ns/10ps
`default_nettype none
module ofr_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic mem_req,
   output logic [23:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack,
   output logic tx_valid,
   output ofr_pkg::ofr_byte_t tx_byte,
   input wire logic tx_ready,
   input wire ofr_pkg::ofr_rx_in_t rx_in,
   output ofr_pkg::ofr_rx_out_t rx_out
);
   logic [4:0] ctrl_q;
   logic [15:0] start_q, end_q, head_q, tail_q, npr_q;
   logic [7:0] free_q, proto_q, hi_q;
   logic [11:0] len_q;
   logic pppoe_q;
   ofr_pkg::ofr_state_t st_q;
   logic [12:0] off_q, ip_start, rel, ihl4_q, ck_off;
   logic [15:0] ip_sum_q, l4_sum_q, word;
   logic wr_en, rd_ok, last_b, csum_on, fin;
   ofr_pkg::ofr_byte_t buf_q [2];
   logic [1:0] cnt_q;
   logic wp_q, rp_q, in_ready, push;
   ofr_pkg::ofr_byte_t push_b;

   function automatic logic [15:0] csum_add(input logic [15:0] a,
                                            input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'h0000, s[16]};
   endfunction

   function automatic logic [23:0] ring_addr(input logic [15:0] pg,
                                             input logic [12:0] off);
      logic [23:0] a;
      a = {pg, 8'h00} + {11'h000, off};
      if (a > {end_q, 8'hff})
         a = a - ({end_q, 8'hff} - {start_q, 8'h00} + 24'h000001);
      return a;
   endfunction

   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   always_comb begin
      pslverr = psel && penable && (paddr > ofr_pkg::A_STAT || paddr[1:0] != 2'b00);
      case (paddr)
         ofr_pkg::A_CTRL: prdata = {27'h0000000, ctrl_q};
         ofr_pkg::A_START: prdata = {16'h0000, start_q};
         ofr_pkg::A_END: prdata = {16'h0000, end_q};
         ofr_pkg::A_HEAD: prdata = {16'h0000, head_q};
         ofr_pkg::A_TAIL: prdata = {16'h0000, tail_q};
         ofr_pkg::A_FREE: prdata = {24'h000000, free_q};
         ofr_pkg::A_STAT: prdata = {29'h00000000, head_q == tail_q, st_q};
         default: prdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_q <= ofr_pkg::CTRL_RST;
         start_q <= ofr_pkg::PTR_RST;
         end_q <= ofr_pkg::PTR_RST;
         tail_q <= ofr_pkg::PTR_RST;
      end else if (wr_en) begin
         case (paddr)
            ofr_pkg::A_CTRL: ctrl_q <= pwdata[4:0];
            ofr_pkg::A_START: start_q <= pwdata[15:0];
            ofr_pkg::A_END: end_q <= pwdata[15:0];
            ofr_pkg::A_TAIL: tail_q <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Receive classifier: one result per descriptor, one cycle later
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_out <= '0;
      end else begin
         rx_out.valid <= rx_in.valid;
         if (rx_in.valid) begin
            rx_out.len_hi <= {rx_in.wrapped && ctrl_q[ofr_pkg::C_WRAP_EN],
                              rx_in.pages, rx_in.len[11:8]};
            rx_out.len_lo <= rx_in.len[7:0];
            if (rx_in.etype < ofr_pkg::ET_MIN_TYPE
                || rx_in.etype == ofr_pkg::ET_IPV6
                || rx_in.etype == ofr_pkg::ET_PPPOE_DISC) begin
               rx_out.non_ip <= 1'b1;
               rx_out.protocol <= ofr_pkg::P_NON_IP;
            end else if (rx_in.etype == ofr_pkg::ET_PPPOE_SESS
                         && (!ctrl_q[ofr_pkg::C_TRANSP]
                             || rx_in.ppp_proto != ofr_pkg::PPP_IPV4)) begin
               rx_out.non_ip <= 1'b1;
               rx_out.protocol <= ofr_pkg::P_NON_IP;
            end else begin
               rx_out.non_ip <= 1'b0;
               rx_out.protocol <= 8'h00;
            end
         end
      end
   end

   // Transmit: header fetch, checksum pass, then send pass
   always_comb begin
      ip_start = ofr_pkg::OFF_BODY;
      if (ctrl_q[ofr_pkg::C_TRANSP]) begin
         ip_start = ofr_pkg::OFF_L2_OPT
            + (ctrl_q[ofr_pkg::C_VLAN] ? ofr_pkg::VLAN_BYTES : 13'h0000)
            + (ctrl_q[ofr_pkg::C_SNAP] ? ofr_pkg::SNAP_BYTES : 13'h0000)
            + (pppoe_q ? ofr_pkg::PPPOE_BYTES : 13'h0000);
      end
      rel = off_q - ip_start;
      case (proto_q)
         ofr_pkg::P_UDP: ck_off = ofr_pkg::CK_UDP;
         ofr_pkg::P_TCP: ck_off = ofr_pkg::CK_TCP;
         default: ck_off = ofr_pkg::CK_ICMP;
      endcase
      csum_on = proto_q != ofr_pkg::P_NON_IP && off_q >= ip_start;
      last_b = off_q == ofr_pkg::OFF_BODY + {1'b0, len_q} - 13'h0001;
      word = rel[0] ? {hi_q, mem_rdata} : {mem_rdata, 8'h00};
      rd_ok = mem_req && mem_ack;
      push_b.last = last_b;
      push_b.data = mem_rdata;
      if (csum_on && rel == ofr_pkg::CK_IP)
         push_b.data = ~ip_sum_q[15:8];
      else if (csum_on && rel == ofr_pkg::CK_IP + 13'h0001)
         push_b.data = ~ip_sum_q[7:0];
      else if (csum_on && rel == ihl4_q + ck_off)
         push_b.data = ~l4_sum_q[15:8];
      else if (csum_on && rel == ihl4_q + ck_off + 13'h0001)
         push_b.data = ~l4_sum_q[7:0];
      push = st_q == ofr_pkg::ST_SEND && rd_ok;
      fin = push && last_b;
   end

   assign mem_req = st_q != ofr_pkg::ST_IDLE
                    && (st_q != ofr_pkg::ST_SEND || in_ready);
   assign mem_addr = ring_addr(head_q, off_q);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= ofr_pkg::ST_IDLE;
         off_q <= 13'h0000;
      end else begin
         case (st_q)
            ofr_pkg::ST_IDLE:
               if (ctrl_q[ofr_pkg::C_EN] && head_q != tail_q) begin
                  st_q <= ofr_pkg::ST_HDR;
                  off_q <= ofr_pkg::OFF_NPR_HI;
               end
            ofr_pkg::ST_HDR:
               if (rd_ok) begin
                  off_q <= off_q + 13'h0001;
                  if (off_q == ofr_pkg::OFF_FLAGS)
                     st_q <= ofr_pkg::ST_SUM;
               end
            ofr_pkg::ST_SUM:
               if (rd_ok) begin
                  off_q <= last_b ? ofr_pkg::OFF_BODY : off_q + 13'h0001;
                  if (last_b)
                     st_q <= ofr_pkg::ST_SEND;
               end
            ofr_pkg::ST_SEND:
               if (rd_ok) begin
                  off_q <= off_q + 13'h0001;
                  if (last_b)
                     st_q <= ofr_pkg::ST_IDLE;
               end
            default: st_q <= ofr_pkg::ST_IDLE;
         endcase
      end
   end

   // Header fields latched from the entry
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         npr_q <= ofr_pkg::PTR_RST;
         len_q <= 12'h000;
         proto_q <= 8'h00;
         pppoe_q <= 1'b0;
      end else if (st_q == ofr_pkg::ST_HDR && rd_ok) begin
         case (off_q)
            ofr_pkg::OFF_NPR_HI: npr_q[15:8] <= mem_rdata;
            ofr_pkg::OFF_NPR_HI + 13'h0001: npr_q[7:0] <= mem_rdata;
            ofr_pkg::OFF_LEN_HI: len_q[11:8] <= mem_rdata[3:0];
            ofr_pkg::OFF_LEN_LO: len_q[7:0] <= mem_rdata;
            ofr_pkg::OFF_PROTO: proto_q <= mem_rdata;
            ofr_pkg::OFF_FLAGS: pppoe_q <= mem_rdata[ofr_pkg::PPPOE_BIT];
            default: ;
         endcase
      end
   end

   // Sums start from zeroed checksum fields, so no masking is needed
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ip_sum_q <= 16'h0000;
         l4_sum_q <= 16'h0000;
         hi_q <= 8'h00;
         ihl4_q <= 13'h0000;
      end else if (st_q == ofr_pkg::ST_HDR) begin
         ip_sum_q <= 16'h0000;
         l4_sum_q <= 16'h0000;
      end else if (st_q == ofr_pkg::ST_SUM && rd_ok && csum_on) begin
         hi_q <= mem_rdata;
         if (rel == 13'h0000)
            ihl4_q <= {7'h00, mem_rdata[3:0], 2'b00};
         if (rel[0] || last_b) begin
            if (rel < ihl4_q)
               ip_sum_q <= csum_add(ip_sum_q, word);
            else if (last_b && proto_q != ofr_pkg::P_ICMP
                     && proto_q != ofr_pkg::P_IGMP)
               l4_sum_q <= csum_add(csum_add(csum_add(l4_sum_q, word),
                  {8'h00, proto_q}),
                  {3'b000, off_q + 13'h0001 - ip_start - ihl4_q});
            else
               l4_sum_q <= csum_add(l4_sum_q, word);
            if (rel >= ofr_pkg::PSEUDO_LO && rel <= ofr_pkg::PSEUDO_HI
                && (proto_q == ofr_pkg::P_UDP || proto_q == ofr_pkg::P_TCP))
               l4_sum_q <= csum_add(l4_sum_q, word);
         end
      end
   end

   // Dequeue completes: link to next entry and return its pages
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         head_q <= ofr_pkg::PTR_RST;
         free_q <= ofr_pkg::FREE_RST;
      end else begin
         if (wr_en && paddr == ofr_pkg::A_HEAD)
            head_q <= pwdata[15:0];
         else if (fin)
            head_q <= npr_q;
         if (wr_en && paddr == ofr_pkg::A_FREE)
            free_q <= pwdata[7:0]
               + (fin ? 8'(({1'b0, len_q} + 13'h0105) >> 8) : 8'h00);
         else if (fin)
            free_q <= free_q
               + 8'(({1'b0, len_q} + 13'h0105) >> 8);
      end
   end

   // Two-entry buffer toward the MAC; a stalled MAC stops memory reads in the send pass only
   assign in_ready = cnt_q != 2'd2;
   assign tx_valid = cnt_q != 2'd0;
   assign tx_byte = buf_q[rp_q];
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         buf_q[0] <= '0;
         buf_q[1] <= '0;
         cnt_q <= 2'd0;
         wp_q <= 1'b0;
         rp_q <= 1'b0;
      end else begin
         if (push) begin
            buf_q[wp_q] <= push_b;
            wp_q <= ~wp_q;
         end
         if (tx_valid && tx_ready)
            rp_q <= ~rp_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, tx_valid && tx_ready};
      end
   end

   property p_empty;
      @(posedge clk_sys) disable iff (rst)
         (st_q == ofr_pkg::ST_IDLE && head_q == tail_q) |=> st_q == ofr_pkg::ST_IDLE;
   endproperty
   a_empty: assert property (p_empty) else $error("Dequeue from empty ring");
   property p_rx_len;
      @(posedge clk_sys) disable iff (rst)
         rx_in.valid |=> rx_out.len_lo == $past(rx_in.len[7:0]);
   endproperty
   a_rx_len: assert property (p_rx_len) else $error("Rx length wrong");
   property p_ipv6;
      @(posedge clk_sys) disable iff (rst)
         rx_in.valid && rx_in.etype == ofr_pkg::ET_IPV6
         |=> rx_out.protocol == ofr_pkg::P_NON_IP;
   endproperty
   a_ipv6: assert property (p_ipv6) else $error("IPv6 not non-IP");
   property p_sess;
      @(posedge clk_sys) disable iff (rst)
         rx_in.valid && ctrl_q[ofr_pkg::C_TRANSP]
         && rx_in.etype == ofr_pkg::ET_PPPOE_SESS
         |=> rx_out.non_ip == (($past(rx_in.ppp_proto)) != ofr_pkg::PPP_IPV4);
   endproperty
   a_sess: assert property (p_sess) else $error("PPPoE session class wrong");
   property p_wrap;
      @(posedge clk_sys) disable iff (rst)
         rx_in.valid && rx_in.wrapped && ctrl_q[ofr_pkg::C_WRAP_EN]
         |=> rx_out.len_hi[7] && rx_out.len_hi[6:4] == $past(rx_in.pages);
   endproperty
   a_wrap: assert property (p_wrap) else $error("Wrap flag wrong");
   property p_head;
      @(posedge clk_sys) disable iff (rst)
         fin && !(wr_en && paddr == ofr_pkg::A_HEAD) |=> head_q == $past(npr_q);
   endproperty
   a_head: assert property (p_head) else $error("Head not advanced");
   property p_hold;
      @(posedge clk_sys) disable iff (rst)
         tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
   endproperty
   a_hold: assert property (p_hold) else $error("Tx byte lost");
   property p_full;
      @(posedge clk_sys) disable iff (rst)
         cnt_q == 2'd2 |-> !push;
   endproperty
   a_full: assert property (p_full) else $error("Push into full buffer");
endmodule // ofr_top
`default_nettype wire

//--- ofr_pkg.sv
package ofr_pkg;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_START = 8'h04;
   localparam logic [7:0] A_END = 8'h08;
   localparam logic [7:0] A_HEAD = 8'h0c;
   localparam logic [7:0] A_TAIL = 8'h10;
   localparam logic [7:0] A_FREE = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   localparam int C_EN = 0;
   localparam int C_TRANSP = 1;
   localparam int C_WRAP_EN = 2;
   localparam int C_VLAN = 3;
   localparam int C_SNAP = 4;
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [15:0] PTR_RST = 16'h0000;
   localparam logic [7:0] FREE_RST = 8'h00;
   localparam logic [12:0] OFF_NPR_HI = 13'h0000;
   localparam logic [12:0] OFF_LEN_HI = 13'h0002;
   localparam logic [12:0] OFF_LEN_LO = 13'h0003;
   localparam logic [12:0] OFF_PROTO = 13'h0004;
   localparam logic [12:0] OFF_FLAGS = 13'h0005;
   localparam logic [12:0] OFF_BODY = 13'h0006;
   localparam logic [12:0] OFF_L2_OPT = 13'h0014;
   localparam logic [12:0] VLAN_BYTES = 13'h0004;
   localparam logic [12:0] SNAP_BYTES = 13'h0008;
   localparam logic [12:0] PPPOE_BYTES = 13'h0008;
   localparam int PPPOE_BIT = 7;
   localparam logic [7:0] P_ICMP = 8'h01;
   localparam logic [7:0] P_IGMP = 8'h02;
   localparam logic [7:0] P_TCP = 8'h06;
   localparam logic [7:0] P_UDP = 8'h11;
   localparam logic [7:0] P_NON_IP = 8'hff;
   localparam logic [15:0] ET_MIN_TYPE = 16'h0600;
   localparam logic [15:0] ET_IPV6 = 16'h86dd;
   localparam logic [15:0] ET_PPPOE_DISC = 16'h8863;
   localparam logic [15:0] ET_PPPOE_SESS = 16'h8864;
   localparam logic [15:0] PPP_IPV4 = 16'h0021;
   localparam logic [12:0] CK_IP = 13'h000a;
   localparam logic [12:0] CK_ICMP = 13'h0002;
   localparam logic [12:0] CK_UDP = 13'h0006;
   localparam logic [12:0] CK_TCP = 13'h0010;
   localparam logic [12:0] PSEUDO_LO = 13'h000c;
   localparam logic [12:0] PSEUDO_HI = 13'h0013;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_HDR = 2'b01, ST_SUM = 2'b10, ST_SEND = 2'b11
   } ofr_state_t;
   typedef struct packed {
      logic valid;
      logic [15:0] etype;
      logic [15:0] ppp_proto;
      logic [11:0] len;
      logic wrapped;
      logic [2:0] pages;
   } ofr_rx_in_t;
   typedef struct packed {
      logic valid;
      logic non_ip;
      logic [7:0] len_hi;
      logic [7:0] len_lo;
      logic [7:0] protocol;
   } ofr_rx_out_t;
   typedef struct packed {
      logic [7:0] data;
      logic last;
   } ofr_byte_t;
endpackage

//--- ofr_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module ofr_mem_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic mem_req,
   input wire logic [23:0] mem_addr,
   input wire logic [3:0] lat,
   output logic [7:0] mem_rdata,
   output logic mem_ack
);
   // Ring pages, filled by the bench acting as software
   logic [7:0] mem [0:4095];
   logic [3:0] wait_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mem_ack <= 1'b0;
         wait_q <= 4'h0;
         mem_rdata <= 8'h5a;
      end else begin
         // Data only good in the ack cycle, so it toggles otherwise
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) begin
            if (wait_q >= lat) begin
               mem_ack <= 1'b1;
               mem_rdata <= mem[mem_addr[11:0]];
               wait_q <= 4'h0;
            end else begin
               wait_q <= wait_q + 4'h1;
            end
         end
      end
   end
endmodule // ofr_mem_model
`default_nettype wire

//--- tb_offload_packet_ring_format.sv
`timescale 1ns/10ps
`default_nettype none
module tb_offload_packet_ring_format;
   logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
   logic mem_req, mem_ack, tx_valid, tx_ready;
   logic [7:0] paddr, mem_rdata;
   logic [31:0] pwdata, prdata;
   logic [23:0] mem_addr;
   logic [3:0] lat;
   logic [2:0] stall_q = 3'h0;
   ofr_pkg::ofr_byte_t tx_byte;
   ofr_pkg::ofr_rx_in_t rx_in;
   ofr_pkg::ofr_rx_out_t rx_out;
   ofr_pkg::ofr_byte_t got_q[$], exp_q[$];
   int err_total = 0, samples_checked = 0, req_seen = 0;
   ofr_top DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .tx_ready(tx_ready), .rx_in(rx_in), .rx_out(rx_out));
   ofr_mem_model u_mem (.clk_sys(clk_sys), .rst(rst), .mem_req(mem_req),
      .mem_addr(mem_addr), .lat(lat), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // MAC side stalls three cycles in eight so the buffer fills
   always @(posedge clk_sys) begin
      stall_q <= stall_q + 3'h1;
      tx_ready <= (stall_q < 3'h5);
      if (tx_valid && tx_ready) got_q.push_back(tx_byte);
      if (mem_req) req_seen++;
   end
   task automatic end_of_test;
      $display("checks=%0d mismatches=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      // Answer is looked at mid-cycle, where it has settled for the edge
      do begin
         @(negedge clk_sys);
         n++;
      end while (!pready && n < 50);
      if (!pready) begin
         err_total++;
         end_of_test;
      end
      q = prdata;
      e = pslverr;
      @(posedge clk_sys);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x,
         input logic xe);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   function automatic logic [15:0] csum(input int b, input int n,
         input logic [31:0] s0);
      logic [31:0] s;
      s = s0;
      for (int i = 0; i < n; i += 2) s += {u_mem.mem[b+i], u_mem.mem[b+i+1]};
      s = (s & 32'hffff) + (s >> 16);
      s = (s & 32'hffff) + (s >> 16);
      return ~s[15:0];
   endfunction
   // ip: bytes of layer-2 header ahead of the IP header, fl: PPPoE flag
   task automatic mk(input logic [15:0] pg, input logic [15:0] nx,
         input logic [7:0] pr, input int len, input int ip,
         input logic fl);
      int b, p, n0, cp;
      logic [15:0] ci, cl;
      logic [31:0] s0;
      b = pg * 256;
      p = b + 6 + ip;
      n0 = exp_q.size();
      s0 = 32'h0;
      cp = pr == ofr_pkg::P_UDP ? 6 : (pr == ofr_pkg::P_TCP ? 16 : 2);
      u_mem.mem[b] = nx[15:8];
      u_mem.mem[b+1] = nx[7:0];
      u_mem.mem[b+2] = 8'(len >> 8);
      u_mem.mem[b+3] = 8'(len);
      u_mem.mem[b+4] = pr;
      u_mem.mem[b+5] = {fl, 7'h00};
      for (int i = 6; i < 6 + len; i++) u_mem.mem[b+i] = 8'(i) ^ pr;
      if (pr != ofr_pkg::P_NON_IP) begin
         u_mem.mem[p] = 8'h45;
         u_mem.mem[p+2] = 8'((len - ip) >> 8);
         u_mem.mem[p+3] = 8'(len - ip);
         u_mem.mem[p+9] = pr;
         for (int i = 0; i < 2; i++) u_mem.mem[p+10+i] = 8'h00;
         for (int i = 0; i < 2; i++)
            u_mem.mem[p+20+cp+i] = 8'h00;
         // Pseudo header: protocol, segment length, both IP addresses
         if (pr == ofr_pkg::P_UDP || pr == ofr_pkg::P_TCP) begin
            s0 = 32'(pr) + 32'(len - ip - 20);
            for (int i = 12; i < 20; i += 2)
               s0 += {u_mem.mem[p+i], u_mem.mem[p+i+1]};
         end
         ci = csum(p, 20, 32'h0);
         cl = csum(p + 20, len - ip - 20, s0);
      end
      for (int i = 6; i < 6 + len; i++)
         exp_q.push_back('{u_mem.mem[b+i], i == 5 + len});
      if (pr != ofr_pkg::P_NON_IP) begin
         exp_q[n0+ip+10].data = ci[15:8];
         exp_q[n0+ip+11].data = ci[7:0];
         exp_q[n0+ip+20+cp].data = cl[15:8];
         exp_q[n0+ip+21+cp].data = cl[7:0];
      end
   endtask
   task automatic wait_bytes(input int n);
      int k;
      k = 0;
      while (got_q.size() < n && k < 4000) begin
         @(posedge clk_sys);
         k++;
      end
      if (got_q.size() < n) begin
         err_total++;
         end_of_test;
      end
   endtask
   task automatic rx_one(input logic [4:0] c, input logic [15:0] et,
         input logic [15:0] pp, input logic ni);
      wr(ofr_pkg::A_CTRL, {27'h0, c});
      @(posedge clk_sys);
      rx_in <= '{1'b1, et, pp, 12'h5a3, 1'b1, 3'h5};
      @(posedge clk_sys);
      rx_in.valid <= 1'b0;
      #1;
      chk({31'h0, rx_out.valid}, 32'h1);
      chk({31'h0, rx_out.non_ip}, {31'h0, ni});
      chk({24'h0, rx_out.protocol}, ni ? 32'hff : 32'h0);
      chk({24'h0, rx_out.len_hi}, {24'h0, c[2], 7'h55});
      chk({24'h0, rx_out.len_lo}, 32'ha3);
      @(posedge clk_sys);
      #1;
      chk({31'h0, rx_out.valid}, 32'h0);
   endtask
   task automatic t_regs;
      rd(ofr_pkg::A_CTRL, 32'h0, 1'b0);
      rd(ofr_pkg::A_HEAD, 32'h0, 1'b0);
      rd(ofr_pkg::A_FREE, 32'h0, 1'b0);
      rd(ofr_pkg::A_STAT, 32'h4, 1'b0);
      rd(8'h1c, 32'h0, 1'b1);
      rd(8'h02, 32'h0, 1'b1);
      wr(ofr_pkg::A_HEAD, 32'h1);
      wr(ofr_pkg::A_TAIL, 32'h1);
      wr(ofr_pkg::A_CTRL, 32'h1);
      req_seen = 0;
      repeat (20) @(posedge clk_sys);
      chk(req_seen, 32'h0);
      wr(ofr_pkg::A_CTRL, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_rx;
      rx_one(5'h00, 16'h05ff, 16'h0, 1'b1);
      rx_one(5'h00, 16'h0600, 16'h0, 1'b0);
      rx_one(5'h00, 16'h86dd, 16'h0, 1'b1);
      rx_one(5'h00, 16'h8864, 16'h0021, 1'b1);
      rx_one(5'h06, 16'h8863, 16'h0021, 1'b1);
      rx_one(5'h06, 16'h8864, 16'h0021, 1'b0);
      rx_one(5'h06, 16'h8864, 16'h0057, 1'b1);
      $display("test rx done");
   endtask
   task automatic t_tx;
      mk(16'h1, 16'h2, ofr_pkg::P_ICMP, 28, 0, 1'b0);
      mk(16'h2, 16'h3, ofr_pkg::P_NON_IP, 40, 0, 1'b0);
      wr(ofr_pkg::A_START, 32'h1);
      wr(ofr_pkg::A_END, 32'h10);
      wr(ofr_pkg::A_FREE, 32'hd);
      wr(ofr_pkg::A_TAIL, 32'h3);
      wr(ofr_pkg::A_CTRL, 32'h1);
      wait_bytes(28);
      lat <= 4'h3;
      wait_bytes(68);
      repeat (10) @(posedge clk_sys);
      chk(got_q.size(), 32'd68);
      for (int i = 0; i < 68; i++)
         chk({23'h0, got_q[i]}, {23'h0, exp_q[i]});
      rd(ofr_pkg::A_HEAD, 32'h3, 1'b0);
      rd(ofr_pkg::A_FREE, 32'hf, 1'b0);
      rd(ofr_pkg::A_STAT, 32'h4, 1'b0);
      // Transparent pass: VLAN tag on both, PPPoE header on the second
      mk(16'h3, 16'h4, ofr_pkg::P_UDP, 50, 18, 1'b0);
      mk(16'h4, 16'h5, ofr_pkg::P_TCP, 70, 26, 1'b1);
      wr(ofr_pkg::A_CTRL, 32'hb);
      wr(ofr_pkg::A_TAIL, 32'h5);
      wait_bytes(188);
      repeat (10) @(posedge clk_sys);
      chk(got_q.size(), 32'd188);
      for (int i = 68; i < 188; i++)
         chk({23'h0, got_q[i]}, {23'h0, exp_q[i]});
      rd(ofr_pkg::A_HEAD, 32'h5, 1'b0);
      rd(ofr_pkg::A_FREE, 32'h11, 1'b0);
      rd(ofr_pkg::A_STAT, 32'h4, 1'b0);
      $display("test tx done");
   endtask
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      lat = 4'h0;
      rx_in = '0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs;
      t_rx;
      t_tx;
      end_of_test;
   end
endmodule // tb_offload_packet_ring_format
`default_nettype wire
